/* inc/rtu_pkg.sv */
/*
 * Shared constants and types of the return instruction unit: opcode patterns,
 * quarter-cycle phases, register offsets, field positions and reset values.
 * Assumes a 16-bit program word, a 21-bit program counter and AXI4-Lite access.
 */
package rtu_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int PC_W = 21;
    localparam int DATA_W = 8;
    localparam int BANK_W = 4;
    localparam int STACK_DEPTH = 31;
    localparam int LEVEL_W = 6;
    localparam int ADDR_W = 4;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [14:0] OP_IRQ_RET_HI = 15'h0008;
    localparam logic [14:0] OP_SUB_RET_HI = 15'h0009;
    localparam logic [7:0] OP_LIT_RET_HI = 8'h0C;

    // ****************************************
    // quarter-cycle phases
    // ****************************************
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_LAST_PC = 4'hC;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_HIGH_PRIO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int STATUS_LEVEL_LSB = 0;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int STATUS_KIND_LSB = 9;
    localparam int STATUS_UNDERFLOW_BIT = 12;
    localparam int STATUS_OVERFLOW_BIT = 13;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        RTU_KIND_NONE,
        RTU_KIND_IRQ,
        RTU_KIND_SUB,
        RTU_KIND_LIT
    } rtu_kind_t;

    typedef struct packed {
        logic [DATA_W-1:0] work;
        logic [DATA_W-1:0] flags;
        logic [BANK_W-1:0] bank;
    } rtu_core_regs_t;

    typedef struct packed {
        logic work;
        logic flags;
        logic bank;
    } rtu_load_t;

    typedef struct packed {
        logic high;
        logic low;
    } rtu_irq_set_t;

endpackage

/* src/rtu_return_stack.sv */
/*
 * Hardware return stack as a shift register of program addresses; entry 0 is
 * the stackTop output. Assumes push and pop are single-cycle strobes.
 */
`timescale 1ns/10ps

module rtu_return_stack
    import rtu_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
) (
    input wire logic ref_clk, // core clock
    input wire logic reset, // async, active high
    input wire logic push, // store pushAddr as new top
    input wire logic [WIDTH-1:0] pushAddr, // address pushed by a call
    input wire logic pop, // discard the top entry
    output logic [WIDTH-1:0] stackTop, // current top entry
    output logic [LEVEL_W-1:0] level, // entries held
    output logic underflow, // pop while empty, pulse
    output logic overflow // push while full, pulse
);

    logic [WIDTH-1:0] entry_q [DEPTH];
    logic [LEVEL_W-1:0] level_q;
    logic isEmpty;
    logic isFull;

    assign isEmpty = (level_q == '0);
    assign isFull = (level_q == LEVEL_W'(DEPTH));
    assign stackTop = entry_q[0];
    assign level = level_q;
    assign underflow = pop && !push && isEmpty;
    assign overflow = push && !pop && isFull;

    // ****************************************
    // entries
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : gEntry
            logic [WIDTH-1:0] below;
            logic [WIDTH-1:0] above;
            assign above = (i == 0) ? pushAddr : entry_q[(i == 0) ? 0 : i - 1];
            assign below = (i == DEPTH - 1) ? '0 : entry_q[(i == DEPTH - 1) ? i : i + 1];
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    entry_q[i] <= '0;
                end else if (push && pop) begin
                    // pop and push together replace only the top
                    if (i == 0) begin
                        entry_q[i] <= pushAddr;
                    end
                end else if (push) begin
                    entry_q[i] <= above;
                end else if (pop) begin
                    entry_q[i] <= below; // [RULE10]
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level_q <= '0;
        end else if (push && !pop && !isFull) begin
            level_q <= level_q + LEVEL_W'(1);
        end else if (pop && !push && !isEmpty) begin
            level_q <= level_q - LEVEL_W'(1);
        end
    end

endmodule

/* src/rtu_return_unit.sv */
/*
 * Execution logic for the three return instructions: decode, stack pop into
 * the program counter, shadow restore, literal load and interrupt re-enable,
 * with an AXI4-Lite register slave. Assumes instructions are offered at Q1 of
 * a free-running four-phase instruction cycle and the core applies the loads.
 */
// Operation
// [RULE1] The interrupt return pops the stack and loads the popped top into the PC.
// [RULE2] The interrupt return sets the high or the low global enable and no other flag.
// [RULE3] Interrupt return with select 1 restores working, flags and bank from shadows.
// [RULE4] Any return with select 0 leaves working, flags and bank untouched.
// [RULE5] No return touches the upper or high PC latches.
// [RULE6] Literal return writes its 8-bit literal to working and pops the PC.
// [RULE7] Subroutine return pops the stack into the PC and affects no flags.
// [RULE8] Subroutine return with select 1 restores working, flags and bank from shadows.
// [RULE9] Each return is one word, two cycles: pop at Q4 of the first, then a flush cycle.
// [RULE10] Each pop exposes the previously pushed address as the new top.
`timescale 1ns/10ps

module rtu_return_unit
    import rtu_pkg::*;
(
    input wire logic ref_clk, // 250 MHz core clock
    input wire logic reset, // async, active high
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte lanes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // core side
    output logic [1:0] phase, // current quarter, 0 = Q1
    input wire logic instValid, // instWord valid at Q1
    input wire logic [15:0] instWord, // fetched program word
    output logic instTaken, // word decoded as a return
    output logic flushing, // second, no-operation cycle
    input wire logic callPush, // core pushes a return address
    input wire logic [PC_W-1:0] callAddr, // address pushed
    input wire rtu_core_regs_t shadowRegs, // working/flags/bank shadows
    input wire rtu_core_regs_t liveRegs, // current working/flags/bank
    output logic [PC_W-1:0] pcValue, // new program counter
    output logic pcLoad, // load pcValue, pulse
    output rtu_core_regs_t regsValue, // values for working/flags/bank
    output rtu_load_t regsLoad, // per-register load, pulse
    output rtu_irq_set_t irqEnableSet // set global enable, pulse
);

    typedef enum {ST_IDLE, ST_EXEC, ST_FLUSH} rtu_state_t;

    // ****************************************
    // decode
    // ****************************************
    rtu_state_t state_q;
    rtu_state_t state_d;
    logic [1:0] phase_q;
    logic [15:0] inst_q;
    rtu_kind_t kind_q;
    rtu_kind_t decKind;
    logic [1:0] ctrl_q;
    logic isQ1;
    logic isQ4;
    logic takeInst;
    logic execNow;
    logic shadowSel;
    logic [PC_W-1:0] stackTop;
    logic [LEVEL_W-1:0] stackLevel;
    logic stackUnder;
    logic stackOver;

    assign isQ1 = (phase_q == PHASE_Q1);
    assign isQ4 = (phase_q == PHASE_Q4);
    assign phase = phase_q;
    assign decKind = (instWord[15:1] == OP_IRQ_RET_HI) ? RTU_KIND_IRQ : // [RULE1]
                     (instWord[15:1] == OP_SUB_RET_HI) ? RTU_KIND_SUB : // [RULE7]
                     (instWord[15:8] == OP_LIT_RET_HI) ? RTU_KIND_LIT : // [RULE6]
                     RTU_KIND_NONE;
    assign takeInst = (state_q == ST_IDLE) && isQ1 && instValid &&
                      (decKind != RTU_KIND_NONE) && ctrl_q[CTRL_ENABLE_BIT];
    assign instTaken = takeInst;
    assign execNow = (state_q == ST_EXEC) && isQ4; // [RULE9]
    assign flushing = (state_q == ST_FLUSH);
    assign shadowSel = inst_q[0] && (kind_q != RTU_KIND_LIT);

    // ****************************************
    // sequencing
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (takeInst) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (isQ4) begin
                    state_d = ST_FLUSH; // [RULE9]
                end
            end
            ST_FLUSH: begin
                // words offered during the flush cycle are dropped
                if (isQ4) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            phase_q <= PHASE_Q1;
            inst_q <= '0;
            kind_q <= RTU_KIND_NONE;
        end else begin
            state_q <= state_d;
            phase_q <= phase_q + 2'h1;
            if (takeInst) begin
                inst_q <= instWord;
                kind_q <= decKind;
            end
        end
    end

    // ****************************************
    // return stack
    // ****************************************
    rtu_return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_W)
    ) uStack (
        .ref_clk(ref_clk),
        .reset(reset),
        .push(callPush),
        .pushAddr(callAddr),
        .pop(execNow), // [RULE1] [RULE7] [RULE6]
        .stackTop(stackTop),
        .level(stackLevel),
        .underflow(stackUnder),
        .overflow(stackOver)
    );

    // ****************************************
    // execution outputs
    // ****************************************
    rtu_core_regs_t regsValue_d;
    rtu_load_t regsLoad_d;
    rtu_irq_set_t irqSet_d;

    always_comb begin
        regsValue_d = liveRegs; // [RULE4]
        regsLoad_d = '0;
        irqSet_d = '0;
        if (execNow) begin
            if (shadowSel) begin
                regsValue_d = shadowRegs; // [RULE3] [RULE8]
                regsLoad_d = '{work: 1'b1, flags: 1'b1, bank: 1'b1};
            end
            if (kind_q == RTU_KIND_LIT) begin
                regsValue_d.work = inst_q[DATA_W-1:0]; // [RULE6]
                regsLoad_d.work = 1'b1;
            end
            if (kind_q == RTU_KIND_IRQ) begin
                // priority being serviced is told by software through the control word
                irqSet_d.high = ctrl_q[CTRL_HIGH_PRIO_BIT]; // [RULE2]
                irqSet_d.low = !ctrl_q[CTRL_HIGH_PRIO_BIT]; // [RULE2]
            end
        end
    end

    // program counter, register loads and enable sets are registered here; no latch output exists to disturb
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pcValue <= '0;
            pcLoad <= 1'b0;
            regsValue <= '0;
            regsLoad <= '0;
            irqEnableSet <= '0;
        end else begin
            pcLoad <= execNow;
            regsValue <= regsValue_d;
            regsLoad <= regsLoad_d;
            irqEnableSet <= irqSet_d;
            if (execNow) begin
                pcValue <= stackTop; // [RULE1] [RULE5] [RULE7]
            end
        end
    end

    // ****************************************
    // register slave
    // ****************************************
    logic [15:0] count_q;
    logic [PC_W-1:0] lastPc_q;
    logic under_q;
    logic over_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awHeld_q;
    logic wHeld_q;
    logic doWrite;
    logic wrCtrl;
    logic wrStatus;
    logic wrMapped;
    logic rdMapped;
    logic [31:0] statusWord;
    logic [31:0] readWord;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrMapped = (awAddr_q == ADDR_CTRL) || (awAddr_q == ADDR_STATUS) ||
                      (awAddr_q == ADDR_COUNT) || (awAddr_q == ADDR_LAST_PC);
    assign wrCtrl = doWrite && (awAddr_q == ADDR_CTRL) && wStrb_q[0];
    assign wrStatus = doWrite && (awAddr_q == ADDR_STATUS) && wStrb_q[1];
    assign s_axi_arready = !s_axi_rvalid;
    assign rdMapped = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS) ||
                      (s_axi_araddr == ADDR_COUNT) || (s_axi_araddr == ADDR_LAST_PC);
    assign statusWord = {18'h0, over_q, under_q, 1'b0, 2'(kind_q), flushing,
                         2'h0, stackLevel};
    assign readWord = (s_axi_araddr == ADDR_CTRL) ? {30'h0, ctrl_q} :
                      (s_axi_araddr == ADDR_STATUS) ? statusWord :
                      (s_axi_araddr == ADDR_COUNT) ? {16'h0, count_q} :
                      (s_axi_araddr == ADDR_LAST_PC) ? {11'h0, lastPc_q} : 32'h0;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readWord;
                s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // sticky stack faults: a new fault in the clearing cycle survives
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            count_q <= '0;
            lastPc_q <= '0;
            under_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= wData_q[1:0];
            end
            if (execNow) begin
                count_q <= count_q + 16'h1;
                lastPc_q <= stackTop;
            end
            under_q <= stackUnder || (under_q && !(wrStatus && wData_q[STATUS_UNDERFLOW_BIT]));
            over_q <= stackOver || (over_q && !(wrStatus && wData_q[STATUS_OVERFLOW_BIT]));
        end
    end

endmodule

/* test/rtu_return_unit_props.sv */
/*
 * Timing checker for the return unit's core side.
 * Assumes it is bound to rtu_return_unit and that shadowRegs stays steady.
 */
`timescale 1ns/10ps

module rtu_return_unit_props
    import rtu_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic reset, // async reset
    input wire logic instTaken, // word taken
    input wire logic [15:0] instWord, // program word
    input wire logic pcLoad, // pc load pulse
    input wire logic flushing, // flush cycle
    input wire rtu_core_regs_t shadowRegs, // shadow copies
    input wire rtu_core_regs_t regsValue, // register values
    input wire rtu_load_t regsLoad, // register loads
    input wire rtu_irq_set_t irqEnableSet // enable set pulses
);
    // ****************************************
    // decode and sequences
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire isIrq = instWord[15:1] == OP_IRQ_RET_HI;
    wire isSub = instWord[15:1] == OP_SUB_RET_HI;
    wire isLit = instWord[15:8] == OP_LIT_RET_HI;
    wire [7:0] litVal = instWord[7:0];
    sequence s_sel_take(bit sel);
        instTaken && (isIrq || isSub) && instWord[0] == sel;
    endsequence
    sequence s_pop;
        !pcLoad [*3] ##1 pcLoad;
    endsequence
    sequence s_flush;
        flushing [*4] ##1 !flushing;
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    chk_pop_time: assert property (instTaken |=> s_pop)
        else $error("pc load not four cycles after take");
    chk_flush_span: assert property (instTaken |-> ##4 s_flush)
        else $error("flush cycle length wrong");
    chk_busy_refuse: assert property (flushing |-> !instTaken)
        else $error("word taken during flush");
    chk_load_pulse: assert property (pcLoad |=> !pcLoad)
        else $error("pc load longer than one cycle");
    chk_irq_enable: assert property (instTaken && isIrq |-> ##4 $onehot(irqEnableSet))
        else $error("interrupt return did not set exactly one enable");
    chk_no_irq: assert property (instTaken && !isIrq |-> ##4 irqEnableSet == 2'h0)
        else $error("enable set by a non-interrupt return");
    chk_shadow_back: assert property (s_sel_take(1) |-> ##4 regsLoad == 3'h7
        && regsValue == shadowRegs)
        else $error("shadow restore missing");
    chk_keep_regs: assert property (s_sel_take(0) |-> ##4 regsLoad == 3'h0)
        else $error("registers loaded without select");
    chk_lit_work: assert property (instTaken && isLit |-> ##4 regsLoad == 3'h4
        && regsValue.work == $past(litVal, 4))
        else $error("literal not loaded to working");
endmodule

/* test/rtu_return_unit_tb_top.sv */
/*
 * Self-checking bench of the return unit: stack pushes, all return kinds,
 * register reads over AXI4-Lite. Assumes the checker module is compiled too.
 */
`timescale 1ns/10ps

module rtu_return_unit_tb_top;
    import rtu_pkg::*;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    wire awready, wready, bvalid, arready, rvalid, instTaken, flushing, pcLoad;
    wire [1:0] bresp, rresp, phase;
    wire [31:0] rdata;
    wire [PC_W-1:0] pcValue;
    logic instValid = 1'h0, callPush = 1'h0;
    logic [15:0] instWord = '0;
    logic [PC_W-1:0] callAddr = '0;
    rtu_core_regs_t shadowRegs = {8'hA5, 8'h3C, 4'h9}, liveRegs = {8'h11, 8'h22, 4'h3};
    rtu_core_regs_t regsValue, capVal;
    rtu_load_t regsLoad, capLoad;
    rtu_irq_set_t irqEnableSet, capIrq;
    int err_total = 0, check_count = 0, capN;
    logic [PC_W-1:0] capPc;
    logic capFlush, capBusy, tk;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [15:0] ops [6] = '{16'h0011, 16'h0012, 16'h0CFF, 16'h0013, 16'h0C00, 16'h0010};
    logic [2:0] expLoad [6] = '{3'h7, 3'h0, 3'h4, 3'h7, 3'h4, 3'h0};
    logic [1:0] expIrq [6] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [PC_W-1:0] stk [6] = '{21'h0F0F0F, 21'h155555, 21'h0AAAAA, 21'h1FFFFF,
        21'h000001, 21'h123456};

    rtu_return_unit u_dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .phase(phase), .instValid(instValid), .instWord(instWord),
        .instTaken(instTaken), .flushing(flushing), .callPush(callPush),
        .callAddr(callAddr), .shadowRegs(shadowRegs), .liveRegs(liveRegs),
        .pcValue(pcValue), .pcLoad(pcLoad), .regsValue(regsValue), .regsLoad(regsLoad),
        .irqEnableSet(irqEnableSet));

    // ****************************************
    // tasks
    // ****************************************
    task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // readies are sampled at the edge itself, before that edge's updates land
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        logic dn;
        dn = 1'h0;
        @(posedge ref_clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1;
        bready <= 1'h1;
        for (int n = 0; n < 200 && !dn; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin r = bresp; bready <= 1'h0; dn = 1'h1; end
        end
        // a response that never comes counts against the run
        if (!dn) err_total++;
    endtask

    task rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        logic dn;
        dn = 1'h0;
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        for (int n = 0; n < 200 && !dn; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin d = rdata; r = rresp; rready <= 1'h0; dn = 1'h1; end
        end
        if (!dn) err_total++;
    endtask

    task push(input logic [PC_W-1:0] a);
        @(posedge ref_clk);
        callPush <= 1'h1; callAddr <= a;
        @(posedge ref_clk);
        callPush <= 1'h0;
    endtask

    // word goes up in Q4 so that it is decoded at the Q1 edge
    task offer(input logic [15:0] w, output logic t);
        @(posedge ref_clk);
        for (int n = 0; n < 8 && phase !== 2'h3; n++) @(posedge ref_clk);
        instValid <= 1'h1; instWord <= w;
        @(posedge ref_clk);
        t = instTaken;
    endtask

    // word stays offered into the flush to prove it is refused there
    task run_ret(input logic [15:0] w);
        offer(w, tk);
        capBusy = 1'h0;
        capN = 0;
        for (int n = 1; n <= 12 && capN == 0; n++) begin
            @(posedge ref_clk);
            if (instTaken !== 1'h0) capBusy = 1'h1;
            if (pcLoad === 1'h1) begin
                capN = n; capPc = pcValue; capLoad = regsLoad; capVal = regsValue;
                capIrq = irqEnableSet; capFlush = flushing;
            end
        end
        instValid <= 1'h0;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial forever #2 ref_clk = ~ref_clk;

    initial begin
        #40000;
        err_total++;
        wrap_up;
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'h0;
        rd_reg(ADDR_CTRL, rd, rsp);
        chk_val("ctrl reset", {30'h0, CTRL_RESET}, rd);
        for (int i = 0; i < 6; i++) push(stk[i]);
        for (int i = 0; i < 6; i++) begin
            if (i == 5) wr(ADDR_CTRL, 32'h3, rsp);
            run_ret(ops[i]);
            chk_val("taken", 32'h1, tk);
            chk_val("pop delay", 32'h4, capN);
            chk_val("taken in flush", 32'h0, capBusy);
            chk_val("flushing", 32'h1, capFlush);
            chk_val("pc", stk[5-i], capPc);
            chk_val("reg load", expLoad[i], capLoad);
            chk_val("irq set", expIrq[i], capIrq);
            if (expLoad[i] == 3'h7) chk_val("shadows", shadowRegs, capVal);
            if (expLoad[i] == 3'h4) chk_val("literal", ops[i][7:0], capVal.work);
        end
        offer(16'h0014, tk);
        instValid <= 1'h0;
        chk_val("non-return", 32'h0, tk);
        wr(ADDR_CTRL, 32'h0, rsp);
        offer(16'h0012, tk);
        instValid <= 1'h0;
        chk_val("disabled take", 32'h0, tk);
        rd_reg(ADDR_COUNT, rd, rsp);
        chk_val("count", 32'h6, rd);
        rd_reg(ADDR_LAST_PC, rd, rsp);
        chk_val("last pc", stk[0], rd);
        rd_reg(ADDR_STATUS, rd, rsp);
        chk_val("status", 32'h200, rd);
        rd_reg(4'h2, rd, rsp);
        chk_val("unmapped rresp", RESP_DECERR, rsp);
        chk_val("unmapped rdata", 32'h0, rd);
        wr(4'h2, 32'h1, rsp);
        chk_val("unmapped bresp", RESP_DECERR, rsp);
        // pop from the emptied stack: sticky underflow, then its clear
        wr(ADDR_CTRL, 32'h1, rsp);
        run_ret(16'h0012);
        chk_val("empty pop pc", 32'h0, capPc);
        wr(ADDR_STATUS, 32'h2000, rsp);
        chk_val("mapped bresp", RESP_OKAY, rsp);
        rd_reg(ADDR_STATUS, rd, rsp);
        chk_val("underflow set", 32'h1400, rd);
        chk_val("mapped rresp", RESP_OKAY, rsp);
        wr(ADDR_STATUS, 32'h1000, rsp);
        rd_reg(ADDR_STATUS, rd, rsp);
        chk_val("underflow clear", 32'h400, rd);
        wrap_up;
    end
endmodule

bind rtu_return_unit rtu_return_unit_props u_props (.ref_clk(ref_clk), .reset(reset),
    .instTaken(instTaken), .instWord(instWord), .pcLoad(pcLoad), .flushing(flushing),
    .shadowRegs(shadowRegs), .regsValue(regsValue), .regsLoad(regsLoad),
    .irqEnableSet(irqEnableSet));
